// file: core/channel_rate_ctrl.sv
// channel rate selection, receive clock and pattern pass outputs
`timescale 1ns/1ns
module channel_rate_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // strap and power-down pins
    input wire logic [2:0] rateSelPin,
    input wire logic [2:0] otherRateSelPin,
    input wire logic chanAPowerDownLow,
    // sensing machines and pattern checker
    input wire logic [1:0] ownArsRate,
    input wire logic [1:0] otherArsRate,
    input wire logic patternError,
    input wire logic [19:0] rxBusIn,
    // serializer settings
    output logic [1:0] txRate,
    output logic [1:0] rxRate,
    output logic autoRateSensing,
    output logic [1:0] clkOutOverride,
    // receive pins, enables low while driving
    output logic chanAReceiveParallelClock,
    output logic chanAReceiveParallelClockOeN,
    output logic [19:0] chanAReceiveParallelBus,
    output logic chanAReceiveParallelBusOeN,
    output logic chanAPatternCheckPass,
    output logic chanAPatternCheckPassOeN,
    // interrupt
    output logic irq
);
    localparam int EV_COUNT_W = rate_sel_pkg::EV_COUNT; // number of event bits

    rate_sel_if rsIf(); // decoder link

    logic [2:0] rateSync1_reg; // pin synchronisers, first stage
    logic [2:0] rateSync2_reg;
    logic [2:0] otherSync1_reg;
    logic [2:0] otherSync2_reg;
    logic pdSync1_reg;
    logic pdSync2_reg;
    logic pdCtrl_reg; // register power down
    logic patternTestEnable_reg; // pattern test enable
    logic ddr_reg; // double data rate
    logic [1:0] swRate_reg; // software rate
    logic [1:0] effRate_reg; // applied rate
    logic [EV_COUNT_W-1:0] istat_reg; // sticky events
    logic [EV_COUNT_W-1:0] imask_reg; // event mask
    logic [3:0] holdCnt_reg; // pass low hold count
    logic [1:0] effRate_next; // rate after conflict check
    logic pdActive; // any power down
    logic [4:0] halfCycles; // divider half period
    logic parClk; // divider output
    logic fallNow; // divider falling strobe
    logic [EV_COUNT_W-1:0] events; // this cycle's events
    logic setupPhase; // apb setup cycle
    logic wrAccept; // apb write completes
    logic mapped; // address is a register
    logic [31:0] rdWord; // read mux
    logic passOn; // pass after hold logic
    logic fallLate_reg; // divider fall, one edge old, lines up with the pin

    // decoder inputs
    assign rsIf.ownCode = rateSync2_reg;
    assign rsIf.otherCode = otherSync2_reg;
    assign rsIf.ownArsRate = ownArsRate;
    assign rsIf.otherArsRate = otherArsRate;
    assign rsIf.swRate = swRate_reg;

    rate_decode uDecode (
        .d(rsIf.decoder)
    );

    // pin synchronisers
    always_ff @(posedge clk) begin
        if (rst) begin
            rateSync1_reg <= 3'h0;
            rateSync2_reg <= 3'h0;
            otherSync1_reg <= 3'h0;
            otherSync2_reg <= 3'h0;
            pdSync1_reg <= 1'b1;
            pdSync2_reg <= 1'b1;
        end else begin
            rateSync1_reg <= rateSelPin;
            rateSync2_reg <= rateSync1_reg;
            otherSync1_reg <= otherRateSelPin;
            otherSync2_reg <= otherSync1_reg;
            pdSync1_reg <= chanAPowerDownLow;
            pdSync2_reg <= pdSync1_reg;
        end
    end

    // pin or register power down
    assign pdActive = !pdSync2_reg || pdCtrl_reg;

    // conflicting codes keep the last rate
    assign effRate_next = rsIf.conflict ? effRate_reg : rsIf.rate;

    // apply rate and clock source to both directions
    always_ff @(posedge clk) begin
        if (rst) begin
            effRate_reg <= 2'h0;
            txRate <= 2'h0;
            rxRate <= 2'h0;
            autoRateSensing <= 1'b0;
            clkOutOverride <= 2'h0;
        end else begin
            effRate_reg <= effRate_next;
            txRate <= effRate_next;
            rxRate <= effRate_next;
            if (!rsIf.conflict) begin
                autoRateSensing <= rsIf.arsOn;
                clkOutOverride <= rsIf.clkOvr;
            end
        end
    end

    // receive clock half period: rate and data mode
    assign halfCycles = (rate_sel_pkg::FULL_HALF_CYCLES << effRate_reg) << ddr_reg;

    par_clk_div uDiv (
        .clk(clk),
        .rst(rst || pdActive),
        .halfCycles(halfCycles),
        .parClk(parClk),
        .fallNow(fallNow)
    );

    // receive clock and bus pins
    always_ff @(posedge clk) begin
        if (rst) begin
            chanAReceiveParallelClock <= 1'b0;
            chanAReceiveParallelBus <= 20'h00000;
            fallLate_reg <= 1'b0;
            chanAReceiveParallelClockOeN <= 1'b0;
            chanAReceiveParallelBusOeN <= 1'b0;
        end else begin
            chanAReceiveParallelClockOeN <= pdActive;
            chanAReceiveParallelBusOeN <= pdActive;
            // pin is the divider output one edge late, glitch free
            chanAReceiveParallelClock <= pdActive ? 1'b0 : parClk;
            // fall strobe delayed by the same edge as the pin
            fallLate_reg <= fallNow;
            // bus moves on the falling clock edge, stable at the rising one
            if (pdActive) begin
                chanAReceiveParallelBus <= 20'h00000;
            end else if (fallLate_reg) begin
                chanAReceiveParallelBus <= rxBusIn;
            end
        end
    end

    // pass hold counter after each error
    always_ff @(posedge clk) begin
        if (rst || !patternTestEnable_reg) begin
            holdCnt_reg <= 4'h0;
        end else if (patternError) begin
            holdCnt_reg <= 4'(rate_sel_pkg::PASS_HOLD_CYCLES);
        end else if (holdCnt_reg != 4'h0) begin
            holdCnt_reg <= holdCnt_reg - 4'h1;
        end
    end

    // pass only when enabled, no error now and hold done
    assign passOn = patternTestEnable_reg && !patternError && (holdCnt_reg == 4'h0);

    // pass pin
    always_ff @(posedge clk) begin
        if (rst) begin
            chanAPatternCheckPass <= 1'b0;
            chanAPatternCheckPassOeN <= 1'b0;
        end else begin
            chanAPatternCheckPassOeN <= pdActive;
            chanAPatternCheckPass <= passOn && !pdActive;
        end
    end

    // event sources
    assign events[rate_sel_pkg::EV_RATE_BIT] = effRate_next != effRate_reg;
    assign events[rate_sel_pkg::EV_ERR_BIT] = patternTestEnable_reg && patternError;
    assign events[rate_sel_pkg::EV_CONFLICT_BIT] = rsIf.conflict;

    // apb phases
    assign setupPhase = psel && !penable;
    assign wrAccept = psel && penable && pready && pwrite && pstrb[0];
    assign mapped = (paddr == rate_sel_pkg::CTRL_OFS) || (paddr == rate_sel_pkg::STAT_OFS) ||
                    (paddr == rate_sel_pkg::ISTAT_OFS) || (paddr == rate_sel_pkg::IMASK_OFS);

    // control register writes
    always_ff @(posedge clk) begin
        if (rst) begin
            pdCtrl_reg <= 1'b0;
            patternTestEnable_reg <= 1'b0;
            ddr_reg <= 1'b0;
            swRate_reg <= rate_sel_pkg::SWRATE_RESET;
        end else if (wrAccept && paddr == rate_sel_pkg::CTRL_OFS) begin
            pdCtrl_reg <= pwdata[rate_sel_pkg::CTRL_PD_BIT];
            patternTestEnable_reg <= pwdata[rate_sel_pkg::CTRL_PTE_BIT];
            ddr_reg <= pwdata[rate_sel_pkg::CTRL_DDR_BIT];
            swRate_reg <= pwdata[rate_sel_pkg::CTRL_SWRATE_LSB +: 2];
        end
    end

    // sticky events, write one to clear, set wins
    always_ff @(posedge clk) begin
        if (rst) begin
            istat_reg <= '0;
        end else if (wrAccept && paddr == rate_sel_pkg::ISTAT_OFS) begin
            istat_reg <= (istat_reg & ~pwdata[EV_COUNT_W-1:0]) | events;
        end else begin
            istat_reg <= istat_reg | events;
        end
    end

    // mask register
    always_ff @(posedge clk) begin
        if (rst) begin
            imask_reg <= rate_sel_pkg::IMASK_RESET;
        end else if (wrAccept && paddr == rate_sel_pkg::IMASK_OFS) begin
            imask_reg <= pwdata[EV_COUNT_W-1:0];
        end
    end

    // interrupt level
    always_ff @(posedge clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(istat_reg & imask_reg);
        end
    end

    // read mux
    always_comb begin
        rdWord = 32'h00000000;
        unique case (paddr)
            rate_sel_pkg::CTRL_OFS: begin
                rdWord[rate_sel_pkg::CTRL_PD_BIT] = pdCtrl_reg;
                rdWord[rate_sel_pkg::CTRL_PTE_BIT] = patternTestEnable_reg;
                rdWord[rate_sel_pkg::CTRL_DDR_BIT] = ddr_reg;
                rdWord[rate_sel_pkg::CTRL_SWRATE_LSB +: 2] = swRate_reg;
            end
            rate_sel_pkg::STAT_OFS: begin
                rdWord[rate_sel_pkg::STAT_RATE_LSB +: 2] = effRate_reg;
                rdWord[rate_sel_pkg::STAT_ARS_BIT] = autoRateSensing;
                rdWord[rate_sel_pkg::STAT_OVR_LSB +: 2] = clkOutOverride;
                rdWord[rate_sel_pkg::STAT_PASS_BIT] = chanAPatternCheckPass;
                rdWord[rate_sel_pkg::STAT_PD_BIT] = pdActive;
                rdWord[rate_sel_pkg::STAT_CODE_LSB +: 3] = rateSync2_reg;
            end
            rate_sel_pkg::ISTAT_OFS: begin
                rdWord[EV_COUNT_W-1:0] = istat_reg;
            end
            rate_sel_pkg::IMASK_OFS: begin
                rdWord[EV_COUNT_W-1:0] = imask_reg;
            end
            default: begin
                rdWord = 32'h00000000;
            end
        endcase
    end

    // apb answer: one wait-free access cycle after setup
    always_ff @(posedge clk) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (setupPhase) begin
            pready <= 1'b1;
            pslverr <= !mapped;
            prdata <= pwrite ? 32'h00000000 : rdWord;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    strap_rate_a: assert property ((rsIf.ownCode <= rate_sel_pkg::CODE_EIGHTH) |=>
        (txRate == $past(rsIf.ownCode[1:0]))) else $error("strap rate not applied");
    soft_rate_a: assert property ((rsIf.ownCode == rate_sel_pkg::CODE_SOFT) |=>
        (txRate == $past(swRate_reg))) else $error("software rate not applied");
    own_sense_a: assert property ((rsIf.ownCode == rate_sel_pkg::CODE_ARS) |=>
        (autoRateSensing && txRate == $past(ownArsRate) && clkOutOverride == 2'h0))
        else $error("own sensing not applied");
    top_prio_a: assert property ((rsIf.ownCode == rate_sel_pkg::CODE_ARS_TOP && !rsIf.conflict) |=>
        (clkOutOverride == 2'h1)) else $error("top clock priority missing");
    slave_follow_a: assert property ((rsIf.ownCode == rate_sel_pkg::CODE_SLAVE &&
        rate_sel_pkg::isAutoSense(rsIf.otherCode)) |=> (rxRate == $past(otherArsRate) && clkOutOverride == 2'h2))
        else $error("slave not following other sensing");
    slave_local_a: assert property ((rsIf.ownCode == rate_sel_pkg::CODE_SLAVE && !rsIf.conflict &&
        !rate_sel_pkg::isAutoSense(rsIf.otherCode)) |=> (txRate == $past(swRate_reg) && clkOutOverride == 2'h0))
        else $error("slave local settings wrong");
    both_dirs_a: assert property (txRate == rxRate) else $error("directions differ");
    reset_low_a: assert property (disable iff (1'b0) rst |=>
        (!chanAReceiveParallelClock && !chanAPatternCheckPass && !chanAReceiveParallelClockOeN))
        else $error("reset outputs not low");
    pd_float_a: assert property (pdActive |=> (chanAReceiveParallelClockOeN && chanAPatternCheckPassOeN))
        else $error("outputs driven in power down");
    pass_error_a: assert property ((patternTestEnable_reg && patternError) |=>
        !chanAPatternCheckPass [*2]) else $error("pass high after error");
    pass_off_a: assert property (!patternTestEnable_reg |=> !chanAPatternCheckPass)
        else $error("pass high while disabled");
    conflict_hold_a: assert property (rsIf.conflict |=> $stable(txRate))
        else $error("rate moved on conflict");
    // receive bus may only change where the receive clock falls
    bus_at_fall_a: assert property (($changed(chanAReceiveParallelBus) && !$past(pdActive)) |->
        $fell(chanAReceiveParallelClock)) else $error("receive bus moved off the falling clock");

    // main scenarios worth seeing at least once

    slave_cover_c: cover property (rsIf.ownCode == rate_sel_pkg::CODE_SLAVE ##1 clkOutOverride == 2'h2);
    pass_cover_c: cover property (chanAPatternCheckPass ##1 !chanAPatternCheckPass);
    pd_cover_c: cover property ($rose(chanAReceiveParallelClockOeN));
    irq_cover_c: cover property ($rose(irq));
    conflict_cover_c: cover property (rsIf.conflict ##1 $stable(txRate));
endmodule

// file: core/rate_sel_pkg.sv
// constants, types and helpers shared by the channel rate control block
// Behaviour
// - codes 000..011 pick full/half/quarter/eighth rate
// - code 100 takes rate from software
// - code 101 runs own rate sensing machine
// - code 110 own sensing, clock-out top priority
// - slave follows other channel's sensing machine
// - slave without other sensing uses own registers
// - selected rate drives transmit and receive alike
// - receive clock aligned with twenty-bit receive bus
// - receive clock is bit rate /20 or /40
// - reset drives receive clock and pass low
// - power down floats receive clock and pass
// - pass high error free, low on error
package rate_sel_pkg;
    // register byte offsets
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STAT_OFS = 12'h004;
    localparam logic [11:0] ISTAT_OFS = 12'h008;
    localparam logic [11:0] IMASK_OFS = 12'h00c;
    // control register fields
    localparam int CTRL_PD_BIT = 0;
    localparam int CTRL_PTE_BIT = 1;
    localparam int CTRL_DDR_BIT = 2;
    localparam int CTRL_SWRATE_LSB = 4;
    localparam logic [1:0] SWRATE_RESET = 2'h0;
    // status register fields
    localparam int STAT_RATE_LSB = 0;
    localparam int STAT_ARS_BIT = 2;
    localparam int STAT_OVR_LSB = 3;
    localparam int STAT_PASS_BIT = 5;
    localparam int STAT_PD_BIT = 6;
    localparam int STAT_CODE_LSB = 8;
    // interrupt event bits
    localparam int EV_RATE_BIT = 0;
    localparam int EV_ERR_BIT = 1;
    localparam int EV_CONFLICT_BIT = 2;
    localparam int EV_COUNT = 3;
    localparam logic [2:0] IMASK_RESET = 3'h0;
    // rate select codes
    localparam logic [2:0] CODE_FULL = 3'h0;
    localparam logic [2:0] CODE_HALF = 3'h1;
    localparam logic [2:0] CODE_QUARTER = 3'h2;
    localparam logic [2:0] CODE_EIGHTH = 3'h3;
    localparam logic [2:0] CODE_SOFT = 3'h4;
    localparam logic [2:0] CODE_ARS = 3'h5;
    localparam logic [2:0] CODE_ARS_TOP = 3'h6;
    localparam logic [2:0] CODE_SLAVE = 3'h7;
    // timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int PASS_HOLD_NS = 40;
    localparam int PASS_HOLD_CYCLES = (PASS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [4:0] FULL_HALF_CYCLES = 5'h01;
    // who overrides the clock output source
    typedef enum logic [1:0] {OVR_NONE, OVR_OWN, OVR_OTHER} clk_ovr_t;
    // true for codes that run a rate sensing machine
    function automatic logic isAutoSense(input logic [2:0] code);
        return (code == CODE_ARS) || (code == CODE_ARS_TOP);
    endfunction
endpackage

// file: core/rate_sel_if.sv
// rate selection inputs and decoded results between control and decoder
`timescale 1ns/1ns
interface rate_sel_if;
    logic [2:0] ownCode; // synchronised own strap code
    logic [2:0] otherCode; // synchronised other channel code
    logic [1:0] ownArsRate; // own sensing machine result
    logic [1:0] otherArsRate; // other sensing machine result
    logic [1:0] swRate; // software rate setting
    logic [1:0] rate; // decoded rate
    logic arsOn; // own sensing machine enabled
    rate_sel_pkg::clk_ovr_t clkOvr; // clock output override
    logic conflict; // illegal pairing of codes
    modport decoder(input ownCode, otherCode, ownArsRate, otherArsRate, swRate,
                    output rate, arsOn, clkOvr, conflict);
    modport control(output ownCode, otherCode, ownArsRate, otherArsRate, swRate,
                    input rate, arsOn, clkOvr, conflict);
endinterface

// file: core/rate_decode.sv
// combinational decode of the rate select code into rate and clock source
`timescale 1ns/1ns
module rate_decode (
    // decode request and result
    rate_sel_if.decoder d
);
    // pick rate source and clock-out override per code
    always_comb begin
        d.rate = d.swRate;
        d.arsOn = 1'b0;
        d.clkOvr = rate_sel_pkg::OVR_NONE;
        d.conflict = 1'b0;
        unique case (d.ownCode)
            // fixed strap rates
            rate_sel_pkg::CODE_FULL, rate_sel_pkg::CODE_HALF,
            rate_sel_pkg::CODE_QUARTER, rate_sel_pkg::CODE_EIGHTH: begin
                d.rate = d.ownCode[1:0];
            end
            // software chosen rate
            rate_sel_pkg::CODE_SOFT: begin
                d.rate = d.swRate;
            end
            // own sensing, clock output left to its select
            rate_sel_pkg::CODE_ARS: begin
                d.arsOn = 1'b1;
                d.rate = d.ownArsRate;
            end
            // own sensing with top clock priority
            rate_sel_pkg::CODE_ARS_TOP: begin
                d.arsOn = 1'b1;
                d.rate = d.ownArsRate;
                d.clkOvr = rate_sel_pkg::OVR_OWN;
                d.conflict = (d.otherCode == rate_sel_pkg::CODE_ARS_TOP);
            end
            // slave mode
            rate_sel_pkg::CODE_SLAVE: begin
                if (rate_sel_pkg::isAutoSense(d.otherCode)) begin
                    d.rate = d.otherArsRate;
                    d.clkOvr = rate_sel_pkg::OVR_OTHER;
                end else begin
                    d.rate = d.swRate;
                    d.conflict = (d.otherCode == rate_sel_pkg::CODE_SLAVE);
                end
            end
        endcase
    end
endmodule

// file: core/par_clk_div.sv
// divider making the receive parallel clock from the core clock
`timescale 1ns/1ns
module par_clk_div (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // half period in core cycles
    input wire logic [4:0] halfCycles,
    // divided clock and its falling-edge strobe
    output logic parClk,
    output logic fallNow
);
    logic [4:0] cnt_reg; // cycles into this half period
    logic wrap; // last cycle of the half period

    // half period ends when the count reaches its length
    assign wrap = (cnt_reg + 5'h01) >= halfCycles;
    // strobe coincides with the edge that drops the clock
    assign fallNow = wrap && parClk;

    // count and toggle
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_reg <= 5'h00;
            parClk <= 1'b0;
        end else if (wrap) begin
            cnt_reg <= 5'h00;
            parClk <= ~parClk;
        end else begin
            cnt_reg <= cnt_reg + 5'h01;
        end
    end
endmodule

// file: bench/board_host_model.sv
// board strap and receive-capture model facing channel a
`timescale 1ns/1ns
module board_host_model (
    // strap requests from the bench
    input wire logic [2:0] ownReq,
    input wire logic [2:0] otherReq,
    input wire logic allowConflict,
    // strap pins to the device
    output logic [2:0] ownPin,
    output logic [2:0] otherPin,
    // receive pins from the device
    input wire logic rxClk,
    input wire logic rxClkOeN,
    input wire logic [19:0] rxBus,
    input wire logic rxBusOeN,
    // last word taken by the host
    output logic [19:0] captured
);
    // illegal pairs reach the pins only when a test asks for them
    always_comb begin
        ownPin = ownReq;
        otherPin = otherReq;
        if (!allowConflict && ownReq == otherReq && ownReq[2:1] == 2'h3) begin
            otherPin = 3'h0;
        end
    end
    // host samples the bus on the receive clock while it is driven
    always @(posedge rxClk) begin
        if (!rxClkOeN && !rxBusOeN) begin
            captured <= rxBus;
        end
    end
endmodule

// file: bench/test_channel_rate_ctrl.sv
// self-checking bench for the channel rate control block
`timescale 1ns/1ns
module test_channel_rate_ctrl;
    logic clk, rst, psel, penable, pwrite, pdLow, patErr, allowConf, pready, pslverr, irq, auto_rate_sensing;
    logic clkPin, clkOeN, busOeN, pass, passOeN;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] ownReq, otherReq, ownPin, otherPin;
    logic [1:0] ownArs, otherArs, txRate, rxRate, ovr;
    logic [19:0] rxIn, bus, cap;
    logic e;
    int errors, checked, rises;
    // device under test, straps come through the board model
    channel_rate_ctrl dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rateSelPin(ownPin), .otherRateSelPin(otherPin), .chanAPowerDownLow(pdLow), .ownArsRate(ownArs),
        .otherArsRate(otherArs), .patternError(patErr), .rxBusIn(rxIn), .txRate(txRate), .rxRate(rxRate),
        .autoRateSensing(auto_rate_sensing), .clkOutOverride(ovr), .chanAReceiveParallelClock(clkPin),
        .chanAReceiveParallelClockOeN(clkOeN), .chanAReceiveParallelBus(bus),
        .chanAReceiveParallelBusOeN(busOeN), .chanAPatternCheckPass(pass),
        .chanAPatternCheckPassOeN(passOeN), .irq(irq));
    // far side: straps and receive capture
    board_host_model host_u (.ownReq(ownReq), .otherReq(otherReq), .allowConflict(allowConf),
        .ownPin(ownPin), .otherPin(otherPin), .rxClk(clkPin), .rxClkOeN(clkOeN), .rxBus(bus),
        .rxBusOeN(busOeN), .captured(cap));
    // 250 mhz core clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // compare one value and count it
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // wait n edges, then let updates settle
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // one apb transfer, waits for pready under a bound
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        e = pslverr;
        if (n >= 50) errors++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // change both straps and wait for the synchronisers
    task automatic code(input logic [2:0] o, input logic [2:0] t);
        @(posedge clk);
        ownReq <= o;
        otherReq <= t;
        wt(6);
    endtask
    // applied rate on both directions and clock-out override
    task automatic rate(input logic [1:0] r, input logic [1:0] v);
        chk("txRate", {30'h0, txRate}, {30'h0, r});
        chk("rxRate", {30'h0, rxRate}, {30'h0, r});
        chk("override", {30'h0, ovr}, {30'h0, v});
    endtask
    // count receive clock rises over 64 core cycles
    task automatic count();
        logic last;
        rises = 0;
        last = clkPin;
        repeat (64) begin
            @(posedge clk);
            #1;
            if (!last && clkPin) rises++;
            last = clkPin;
        end
    endtask
    // synchronous reset held for ten cycles, called at time zero or at an edge
    task automatic doReset();
        rst <= 1'b1;
        wt(5);
        chk("clkInReset", {29'h0, clkPin, clkOeN, passOeN}, 32'h0);
        chk("passInReset", {31'h0, pass}, 32'h0);
        repeat (5) @(posedge clk);
        rst <= 1'b0;
    endtask
    // closing verdict
    task automatic print_verdict();
        if (errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        #80000;
        errors++;
        print_verdict();
    end
    // main sequence
    initial begin
        {psel, penable, pwrite, patErr, allowConf, errors, checked} = '0;
        {paddr, pwdata, ownReq, otherReq, ownArs, otherArs} = '0;
        pdLow = 1'b1;
        rxIn = 20'habcde;
        doReset();
        apb(1'b0, rate_sel_pkg::CTRL_OFS, 32'h0);
        chk("ctrlReset", rd, 32'h0);
        apb(1'b0, rate_sel_pkg::IMASK_OFS, 32'h0);
        chk("imaskReset", rd, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped", {rd[30:0], e}, 32'h1);
        for (int c = 0; c < 4; c++) begin
            code(c[2:0], 3'h0);
            rate(c[1:0], 2'h0);
        end
        apb(1'b0, rate_sel_pkg::STAT_OFS, 32'h0);
        chk("statCode", {29'h0, rd[10:8]}, 32'h3);
        apb(1'b1, rate_sel_pkg::CTRL_OFS, 32'h20);
        code(rate_sel_pkg::CODE_SOFT, 3'h0);
        rate(2'h2, 2'h0);
        @(posedge clk) ownArs <= 2'h3;
        otherArs <= 2'h1;
        code(rate_sel_pkg::CODE_ARS, 3'h0);
        rate(2'h3, 2'h0);
        chk("arsOn", {31'h0, auto_rate_sensing}, 32'h1);
        code(rate_sel_pkg::CODE_ARS_TOP, 3'h0);
        rate(2'h3, 2'h1);
        code(rate_sel_pkg::CODE_SLAVE, rate_sel_pkg::CODE_ARS);
        rate(2'h1, 2'h2);
        code(rate_sel_pkg::CODE_SLAVE, rate_sel_pkg::CODE_ARS_TOP);
        rate(2'h1, 2'h2);
        code(rate_sel_pkg::CODE_SLAVE, 3'h0);
        rate(2'h2, 2'h0);
        code(rate_sel_pkg::CODE_ARS, 3'h0);
        allowConf <= 1'b1;
        code(rate_sel_pkg::CODE_ARS_TOP, rate_sel_pkg::CODE_ARS_TOP);
        @(posedge clk) ownArs <= 2'h1;
        wt(3);
        rate(2'h3, 2'h0);
        apb(1'b0, rate_sel_pkg::ISTAT_OFS, 32'h0);
        chk("conflictEv", {31'h0, rd[2]}, 32'h1);
        allowConf <= 1'b0;
        code(3'h0, 3'h0);
        count();
        chk("sdrFull", rises, 32'd32);
        chk("capture", {12'h0, cap}, {12'h0, rxIn});
        apb(1'b1, rate_sel_pkg::CTRL_OFS, 32'h24);
        code(3'h1, 3'h0);
        count();
        chk("ddrHalf", rises, 32'd8);
        apb(1'b1, rate_sel_pkg::ISTAT_OFS, 32'h7);
        apb(1'b1, rate_sel_pkg::IMASK_OFS, 32'h2);
        apb(1'b1, rate_sel_pkg::CTRL_OFS, 32'h2);
        wt(3);
        chk("passClean", {30'h0, pass, irq}, 32'h2);
        @(posedge clk) patErr <= 1'b1;
        @(posedge clk) patErr <= 1'b0;
        wt(2);
        chk("passErr", {30'h0, pass, irq}, 32'h1);
        wt(7);
        chk("passHold", {31'h0, pass}, 32'h0);
        wt(6);
        chk("passBack", {31'h0, pass}, 32'h1);
        apb(1'b1, rate_sel_pkg::ISTAT_OFS, 32'h2);
        wt(3);
        chk("irqClear", {31'h0, irq}, 32'h0);
        apb(1'b1, rate_sel_pkg::IMASK_OFS, 32'h0);
        patErr <= 1'b1;
        @(posedge clk) patErr <= 1'b0;
        wt(3);
        chk("irqMasked", {31'h0, irq}, 32'h0);
        apb(1'b1, rate_sel_pkg::CTRL_OFS, 32'h0);
        wt(3);
        chk("passOff", {31'h0, pass}, 32'h0);
        apb(1'b1, rate_sel_pkg::CTRL_OFS, 32'h1);
        wt(3);
        chk("regPdFloat", {30'h0, clkOeN, passOeN}, 32'h3);
        apb(1'b1, rate_sel_pkg::CTRL_OFS, 32'h0);
        pdLow <= 1'b0;
        wt(6);
        chk("pinPdFloat", {29'h0, clkOeN, passOeN, busOeN}, 32'h7);
        @(posedge clk) pdLow <= 1'b1;
        repeat (4) @(posedge clk);
        doReset();
        wt(3);
        chk("afterReset", {30'h0, clkOeN, passOeN}, 32'h0);
        print_verdict();
    end
endmodule
